// file: src/pmr_defines.vh
// Offsets, field positions, reset values and codes of the power registers.
`ifndef PMR_DEFINES_VH
`define PMR_DEFINES_VH

`define PMR_OFS_CAP_ID 8'hA0
`define PMR_OFS_CAP 8'hA2
`define PMR_OFS_CSR 8'hA4

`define PMR_CAP_ID_VAL 8'h01
`define PMR_NEXT_PTR_VAL 8'h00
`define PMR_CAP_RESET 16'hFE12

`define PMR_CAP_COLD_BIT 15
`define PMR_CAP_AUX_BIT 4
`define PMR_CAP_FIXED 16'h7E22

`define PMR_CSR_STS_BIT 15
`define PMR_CSR_EN_BIT 8
`define PMR_CSR_PS_LO 0
`define PMR_CSR_PS_HI 1

`define PMR_PS_D0 2'h0
`define PMR_PS_D1 2'h1
`define PMR_PS_D2 2'h2
`define PMR_PS_D3HOT 2'h3

`define PMR_FUNC_RST_CYC 4'h4

`endif

// file: src/pmr_func_reset.v
// Stretches the internal function reset fired by a D3hot to D0 change.
`timescale 1ns/10ps
module pmr_func_reset (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Trigger and reset output
   input wire fire_i,
   output reg func_rst_n_o
);
`include "pmr_defines.vh"

   reg [3:0] cnt_r;
   reg [3:0] cnt_nxt;

   always @* begin
      cnt_nxt = cnt_r;
      if (fire_i) begin
         cnt_nxt = `PMR_FUNC_RST_CYC;
      end else if (cnt_r != 4'h0) begin
         cnt_nxt = cnt_r - 4'h1;
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= 4'h0;
         func_rst_n_o <= 1'b1;
      end else begin
         cnt_r <= cnt_nxt;
         func_rst_n_o <= (cnt_nxt == 4'h0);
      end
   end

endmodule

// file: src/pmr_regs.v
// Power-management capability and control/status registers.
// Notes on behaviour
// - D3cold wake-support bit 15 resets to one and is writable.
// - Wake-support bits 14 to 11 are read-only ones.
// - Intermediate-state support bits 10 and 9 read as one.
// - Capability bits 8 to 6 read zero and ignore writes.
// - Special-initialization bit 5 reads as one.
// - Auxiliary-supply bit 4 mirrors capability bit 15.
// - Wake-clock bit 3 reads zero.
// - Version field bits 2 to 0 reads 010.
// - D3hot to D0 write pulses an internal function reset.
// - That internal reset leaves these registers untouched.
// - Wake status sets on any wake event, enable or not.
// - Writing one clears wake status and releases wake unless a wake event comes in that cycle; zero does nothing.
// - Report scale and report select fields read zero.
// - Wake output never asserts while wake enable is clear.
// - Control/status bits 7 to 2 read zero.
// - Power-state field reports and accepts 00 D0 to 11 D3hot.
// - Capability identifier byte reads 01h.
`timescale 1ns/10ps
module pmr_regs (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Configuration access, dword address with byte enables
   input wire [7:0] cfg_addr_i,
   input wire cfg_wr_i,
   input wire cfg_rd_i,
   input wire [3:0] cfg_be_i,
   input wire [31:0] cfg_wdata_i,
   output reg [31:0] cfg_rdata_o,
   // Wake event and wake pin
   input wire wake_event_i,
   output reg wake_n_o,
   // State reports
   output reg [1:0] power_state_o,
   output reg func_rst_n_o
);
`include "pmr_defines.vh"

   reg cold_wake_r;
   reg wake_status_r;
   reg wake_enable_r;
   reg [1:0] power_state_field_r;
   reg fire_r;
   wire func_rst_n;
   wire [15:0] cap_val;
   wire [15:0] csr_val;
   wire [5:0] dw_sel;
   wire hit_a0;
   wire hit_a4;
   wire wr_cap_hi;
   wire wr_csr_lo;
   wire wr_csr_hi;
   wire clr_sts;
   wire sts_nxt;
   wire en_nxt;

   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = (a[7:2] == ofs[7:2]);
      end
   endfunction

   assign dw_sel = cfg_addr_i[7:2];
   assign hit_a0 = hit(cfg_addr_i, `PMR_OFS_CAP_ID);
   assign hit_a4 = hit(cfg_addr_i, `PMR_OFS_CSR);
   assign wr_cap_hi = cfg_wr_i && hit_a0 && cfg_be_i[3];
   assign wr_csr_lo = cfg_wr_i && hit_a4 && cfg_be_i[0];
   assign wr_csr_hi = cfg_wr_i && hit_a4 && cfg_be_i[1];

   // Fixed bits, plus cold_wake_r at bit 15 and its mirror at bit 4.
   assign cap_val = `PMR_CAP_FIXED |
      ({15'h0000, cold_wake_r} << `PMR_CAP_COLD_BIT) |
      ({15'h0000, cold_wake_r} << `PMR_CAP_AUX_BIT);

   // Scale, select and reserved bits are constant zero.
   assign csr_val = {wake_status_r, 6'h00, wake_enable_r, 6'h00,
      power_state_field_r};

   assign clr_sts = wr_csr_hi && cfg_wdata_i[`PMR_CSR_STS_BIT];
   // A wake event in the clearing cycle wins over the clear.
   assign sts_nxt = wake_event_i | (wake_status_r & ~clr_sts);
   assign en_nxt = wr_csr_hi ? cfg_wdata_i[`PMR_CSR_EN_BIT] :
      wake_enable_r;

   // Only rst_n_i resets these; the function reset spares them.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cold_wake_r <= 1'b1;
         wake_status_r <= 1'b0;
         wake_enable_r <= 1'b0;
         power_state_field_r <= `PMR_PS_D0;
         fire_r <= 1'b0;
         wake_n_o <= 1'b1;
         power_state_o <= `PMR_PS_D0;
         cfg_rdata_o <= 32'h00000000;
      end else begin
         if (wr_cap_hi) begin
            cold_wake_r <= cfg_wdata_i[16 + `PMR_CAP_COLD_BIT];
         end
         wake_status_r <= sts_nxt;
         wake_enable_r <= en_nxt;
         fire_r <= 1'b0;
         if (wr_csr_lo) begin
            power_state_field_r <= cfg_wdata_i[1:0];
            if (power_state_field_r == `PMR_PS_D3HOT &&
                cfg_wdata_i[1:0] == `PMR_PS_D0) begin
               fire_r <= 1'b1;
            end
         end
         wake_n_o <= ~(sts_nxt & en_nxt);
         if (wr_csr_lo) begin
            power_state_o <= cfg_wdata_i[1:0];
         end
         if (cfg_rd_i) begin
            case (dw_sel)
               6'h28: cfg_rdata_o <= {cap_val, `PMR_NEXT_PTR_VAL,
                  `PMR_CAP_ID_VAL};
               6'h29: cfg_rdata_o <= {16'h0000, csr_val};
               default: cfg_rdata_o <= 32'h00000000;
            endcase
         end
      end
   end

   pmr_func_reset pmr_func_reset_inst (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .fire_i(fire_r),
      .func_rst_n_o(func_rst_n)
   );

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         func_rst_n_o <= 1'b1;
      end else begin
         func_rst_n_o <= func_rst_n;
      end
   end

endmodule

// file: dv/pmr_host.sv
// Configuration host model issuing register reads and writes.
`timescale 1ns/10ps
module pmr_host (
   // Bus to the registers
   input wire clk_i,
   input wire [31:0] rdata_i,
   output logic wr_o = 1'h0, rd_o = 1'h0,
   output logic [3:0] be_o = 4'h0,
   output logic [7:0] adr_o = 8'h00,
   output logic [31:0] wd_o = 32'h0
);
   task cfg_write(input [7:0] a, input [3:0] b, input [31:0] d);
      @(negedge clk_i) {adr_o, be_o, wd_o, wr_o} = {a, b, d, 1'h1};
      @(negedge clk_i) wr_o = 1'h0;
   endtask
   task cfg_read(input [7:0] a, output [31:0] d);
      @(negedge clk_i) {adr_o, rd_o} = {a, 1'h1};
      @(negedge clk_i) rd_o = 1'h0;
      d = rdata_i;
   endtask
endmodule

// file: dv/pmr_regs_checker.sv
// Port assertions for the power registers.
`timescale 1ns/10ps
module pmr_regs_checker (
   // Watched ports
   input wire clk_i, rst_n_i, cfg_wr_i, cfg_rd_i, wake_event_i, wake_n_o,
   input wire func_rst_n_o,
   input wire [1:0] power_state_o,
   input wire [3:0] cfg_be_i,
   input wire [7:0] cfg_addr_i,
   input wire [31:0] cfg_wdata_i, cfg_rdata_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire c = cfg_rd_i && cfg_addr_i == 8'hA0;
   wire s = cfg_rd_i && cfg_addr_i == 8'hA4;
   wire w0 = cfg_wr_i && cfg_addr_i == 8'hA4 && cfg_be_i[0];
   wire w1 = cfg_wr_i && cfg_addr_i == 8'hA4 && cfg_be_i[1];
   cap_fixed_a: assert property (
      c |=> cfg_rdata_o[30:0] == {10'h3F1, cfg_rdata_o[31], 20'h20001})
      else $error("cap");
   csr_rsvd_a: assert property (
      s |=> (cfg_rdata_o & 32'hFFFF7EFC) == 32'h0) else $error("rsvd");
   state_rd_a: assert property (
      s |=> cfg_rdata_o[1:0] == $past(power_state_o)) else $error("rd");
   state_wr_a: assert property (
      w0 |=> power_state_o == $past(cfg_wdata_i[1:0])) else $error("wr");
   func_rst_a: assert property (
      w0 && cfg_wdata_i[1:0] == 2'h0 && power_state_o == 2'h3 |->
      ##3 !func_rst_n_o [*4] ##1 func_rst_n_o) else $error("frst");
   rst_keep_a: assert property (
      !func_rst_n_o |-> $stable(power_state_o)) else $error("keep");
   wake_clr_a: assert property (
      w1 && cfg_wdata_i[15] && !wake_event_i |=> wake_n_o) else $error("clr");
   wake_gate_a: assert property (
      w1 && !cfg_wdata_i[8] |=> wake_n_o) else $error("gate");
   cover property (c);
   cover property ($fell(func_rst_n_o));
   cover property ($fell(wake_n_o));
endmodule
bind pmr_regs pmr_regs_checker pmr_regs_checker_inst (.clk_i(clk_i),
   .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
   .wake_event_i(wake_event_i), .wake_n_o(wake_n_o),
   .func_rst_n_o(func_rst_n_o), .power_state_o(power_state_o),
   .cfg_be_i(cfg_be_i), .cfg_addr_i(cfg_addr_i),
   .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o));

// file: dv/pmr_regs_tb.sv
// Self-checking bench for the power registers.
`timescale 1ns/10ps
module pmr_regs_tb;
   logic clk_i = 1'h0, rst_n_i = 1'h0, ev = 1'h0;
   wire wr, rd, wk, fr;
   wire [1:0] ps;
   wire [3:0] be;
   wire [7:0] ad;
   wire [31:0] wd, q;
   logic [31:0] d;
   int n_mismatch = 0, num_checks = 0;
   initial forever #12.5 clk_i = ~clk_i;
   pmr_host pmr_host_inst (.clk_i(clk_i), .rdata_i(q), .wr_o(wr), .rd_o(rd),
      .be_o(be), .adr_o(ad), .wd_o(wd));
   pmr_regs pmr_regs_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_addr_i(ad),
      .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_be_i(be), .cfg_wdata_i(wd),
      .cfg_rdata_o(q), .wake_event_i(ev), .wake_n_o(wk),
      .power_state_o(ps), .func_rst_n_o(fr));
   task chk(input [31:0] got, input [31:0] exp);
      num_checks++;
      n_mismatch += (got !== exp);
      if (got !== exp) $display("Error t=%0t got=%h exp=%h", $time, got, exp);
   endtask
   task rdc(input [7:0] a, input [31:0] exp);
      pmr_host_inst.cfg_read(a, d);
      chk(d, exp);
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task t_cap;
      rdc(8'hA0, 32'hFE32_0001);
      pmr_host_inst.cfg_write(8'hA0, 4'hC, 32'h0);
      rdc(8'hA0, 32'h7E22_0001);
   endtask
   task t_state;
      for (int i = 0; i < 4; i++) begin
         pmr_host_inst.cfg_write(8'hA4, 4'h3, 32'h100 | i);
         chk(ps, i);
         rdc(8'hA4, 32'h100 | i);
      end
      pmr_host_inst.cfg_write(8'hA4, 4'h1, 32'h0);
      repeat (2) @(negedge clk_i);
      chk(fr, 32'h0);
      repeat (4) @(negedge clk_i);
      chk(fr, 32'h1);
      chk(ps, 32'h0);
      rdc(8'hA4, 32'h100);
   endtask
   task t_wake;
      @(negedge clk_i) ev = 1'h1;
      @(negedge clk_i) ev = 1'h0;
      chk(wk, 32'h0);
      rdc(8'hA4, 32'h8100);
      pmr_host_inst.cfg_write(8'hA4, 4'h2, 32'h8100);
      chk(wk, 32'h1);
      pmr_host_inst.cfg_write(8'hA4, 4'h2, 32'h0);
      @(negedge clk_i) ev = 1'h1;
      @(negedge clk_i) ev = 1'h0;
      chk(wk, 32'h1);
      rdc(8'hA4, 32'h8000);
      pmr_host_inst.cfg_write(8'hA4, 4'h2, 32'h0);
      rdc(8'hA4, 32'h8000);
   endtask
   initial begin
      repeat (5) @(negedge clk_i);
      rst_n_i = 1'h1;
      t_cap;
      t_state;
      t_wake;
      tally_and_finish;
   end
   initial begin
      #20000;
      n_mismatch++;
      tally_and_finish;
   end
endmodule
